// ### inc/nvirq_pkg.sv
// Behaviour
// - 240 lines, each with an 8-bit priority
// - priority rewritable anytime, arbitration uses new value
// - track nested handlers, tail-chain pending on return
// - full access privileged; user may set pending
// - other unprivileged access to a mapped address answers with bus fault
// - sleep after handler on return to thread
// - level still high at return pends again
// - pulse during handler pends while still active
// - extra pulses while pending are not counted
// - line count register reports groups of 32 minus one
// - active status words read-only, zero after reset
package nvirq_pkg;
  localparam int NUM_LINES   = 240;
  localparam int PRIO_W      = 8;
  localparam int ID_W        = 8;
  localparam int STACK_DEPTH = 32;

  localparam logic [31:0] ADDR_LINE_COUNT = 32'hE000E004;
  localparam logic [31:0] ADDR_CTRL       = 32'hE000E008;
  localparam logic [31:0] ADDR_EVT_STATUS = 32'hE000E00C;
  localparam logic [31:0] ADDR_EVT_MASK   = 32'hE000E010;
  localparam logic [31:0] ADDR_CORE_STATE = 32'hE000E014;
  localparam logic [31:0] ADDR_EN_SET     = 32'hE000E100;
  localparam logic [31:0] ADDR_EN_CLR     = 32'hE000E180;
  localparam logic [31:0] ADDR_PEND_SET   = 32'hE000E200;
  localparam logic [31:0] ADDR_PEND_CLR   = 32'hE000E280;
  localparam logic [31:0] ADDR_ACTIVE     = 32'hE000E300;
  localparam logic [31:0] ADDR_PRIO       = 32'hE000E400;
  localparam logic [5:0]  PRIO_WORDS      = 6'h3C;

  localparam logic [3:0]  LINE_GROUP_COUNT = 4'h7;
  localparam logic [31:0] RST_WORD         = 32'h00000000;
  localparam logic [2:0]  RST_CTRL         = 3'h0;
  localparam logic [3:0]  RST_EVT          = 4'h0;

  localparam int CTRL_USER_PEND  = 0;
  localparam int CTRL_SLEEP_EXIT = 1;
  localparam int CTRL_DEEP_SEL   = 2;

  localparam int EVT_W         = 4;
  localparam int EVT_BUS_FAULT = 0;
  localparam int EVT_UNMAPPED  = 1;
  localparam int EVT_SLEEP     = 2;
  localparam int EVT_WAKE      = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    NVIRQ_RUN,
    NVIRQ_SLEEP_IRQ,
    NVIRQ_SLEEP_EVT
  } nvirq_sleep_t;
endpackage : nvirq_pkg

// ### hw/nvirq_arbiter.sv
`timescale 1ns/1ps
module nvirq_arbiter (
  input  wire logic [nvirq_pkg::NUM_LINES-1:0]                   req,
  input  wire logic [nvirq_pkg::NUM_LINES*nvirq_pkg::PRIO_W-1:0] prioFlat,
  output logic                                                   winValid,
  output logic [nvirq_pkg::ID_W-1:0]                             winId,
  output logic [nvirq_pkg::PRIO_W-1:0]                           winPrio
);
  import nvirq_pkg::*;

  logic              stValid [0:NUM_LINES];
  logic [ID_W-1:0]   stId    [0:NUM_LINES];
  logic [PRIO_W-1:0] stPrio  [0:NUM_LINES];

  assign stValid[0] = 1'b0;
  assign stId[0]    = 8'h00;
  assign stPrio[0]  = 8'hFF;

  // strict less-than keeps the lower line number on equal priority
  genvar i;
  generate
    for (i = 0; i < NUM_LINES; i++) begin : g_stage
      logic take;
      assign take = req[i] &&
                    (!stValid[i] || prioFlat[i*PRIO_W +: PRIO_W] < stPrio[i]);
      assign stValid[i+1] = stValid[i] || req[i];
      assign stId[i+1]    = take ? ID_W'(i) : stId[i];
      assign stPrio[i+1]  = take ? prioFlat[i*PRIO_W +: PRIO_W] : stPrio[i];
    end
  endgenerate

  assign winValid = stValid[NUM_LINES];
  assign winId    = stId[NUM_LINES];
  assign winPrio  = stPrio[NUM_LINES];

  always_comb begin
    a_win_is_request:
      assert final (!winValid ||
              (req[winId] && prioFlat[winId*PRIO_W +: PRIO_W] == winPrio))
      else $error("winner is not a requesting line at its priority");
  end
endmodule : nvirq_arbiter

// ### hw/nvirq_ctrl.sv
`timescale 1ns/1ps
module nvirq_ctrl (
  input  wire logic                               sys_clk,
  input  wire logic                               rst,
  input  wire logic [31:0]                        awaddr,
  input  wire logic [2:0]                         awprot,
  input  wire logic                               awvalid,
  output logic                                    awready,
  input  wire logic [31:0]                        wdata,
  input  wire logic [3:0]                         wstrb,
  input  wire logic                               wvalid,
  output logic                                    wready,
  output logic [1:0]                              bresp,
  output logic                                    bvalid,
  input  wire logic                               bready,
  input  wire logic [31:0]                        araddr,
  input  wire logic [2:0]                         arprot,
  input  wire logic                               arvalid,
  output logic                                    arready,
  output logic [31:0]                             rdata,
  output logic [1:0]                              rresp,
  output logic                                    rvalid,
  input  wire logic                               rready,
  input  wire logic [nvirq_pkg::NUM_LINES-1:0]    irqIn,
  input  wire logic                               irqAck,
  input  wire logic                               excReturn,
  input  wire logic                               waitIrqInstr,
  input  wire logic                               waitEventInstr,
  input  wire logic                               sendEventInstr,
  output logic                                    irqReq,
  output logic [nvirq_pkg::ID_W-1:0]              irqId,
  output logic [nvirq_pkg::PRIO_W-1:0]            irqPrio,
  output logic                                    tailChain,
  output logic                                    sleeping,
  output logic                                    deepSleep,
  output logic                                    eventOut,
  output logic                                    intrOut
);
  import nvirq_pkg::*;

  logic [NUM_LINES-1:0] enableReg, pendingReg, activeReg, irqPrevReg;
  logic [PRIO_W-1:0]    prioReg [0:NUM_LINES-1];
  logic [NUM_LINES*PRIO_W-1:0] prioFlat;
  logic [ID_W-1:0]      stackMem [0:STACK_DEPTH-1];
  logic [5:0]           depthReg;
  logic [2:0]           ctrlReg;
  logic [EVT_W-1:0]     evtStatusReg, evtMaskReg, evtSet;
  nvirq_sleep_t         stateReg, stateNext;
  logic                 eventLatchReg;

  // write channel capture
  logic        awGotReg, wGotReg;
  logic [31:0] wrAddrReg, wrDataReg;
  logic [2:0]  wrProtReg;
  logic [3:0]  wrStrbReg;
  logic        wrDo, wrEff, wrMapped, wrPermit, wrFull;
  logic        wrEnSet, wrEnClr, wrPendSet, wrPendClr, wrPrio;
  logic [1:0]  wrResp;
  logic [255:0] wrVec;
  logic [NUM_LINES-1:0] wrLines;

  // read path
  logic [31:0] rdNext;
  logic [1:0]  rrNext;
  logic        rdHit;

  // arbitration and nesting
  logic                 winValid, actValid, preempt, ackTake, retTake;
  logic [ID_W-1:0]      winId, actId, retId;
  logic [PRIO_W-1:0]    winPrio, actPrio;
  logic [5:0]           depthM1;
  logic [NUM_LINES-1:0] ackHot, retHot, hwSet, riseVec, retHotQ;

  function automatic logic [31:0] bankWord(input logic [NUM_LINES-1:0] v,
                                           input logic [2:0]           idx);
    logic [255:0] w;
    w = {16'h0000, v};
    return w[{idx, 5'h00} +: 32];
  endfunction : bankWord

  genvar g;
  generate
    for (g = 0; g < NUM_LINES; g++) begin : g_flat
      assign prioFlat[g*PRIO_W +: PRIO_W] = prioReg[g];
    end
  endgenerate

  // ---------------- write address/data decode ----------------
  assign wrDo      = awGotReg && wGotReg && !bvalid;
  assign wrFull    = (wrStrbReg == 4'hF);
  assign wrEnSet   = wrAddrReg[31:5] == ADDR_EN_SET[31:5];
  assign wrEnClr   = wrAddrReg[31:5] == ADDR_EN_CLR[31:5];
  assign wrPendSet = wrAddrReg[31:5] == ADDR_PEND_SET[31:5];
  assign wrPendClr = wrAddrReg[31:5] == ADDR_PEND_CLR[31:5];
  assign wrPrio    = (wrAddrReg[31:8] == ADDR_PRIO[31:8]) &&
                     (wrAddrReg[7:2] < PRIO_WORDS) &&
                     (wrAddrReg[1:0] == 2'h0);
  assign wrMapped  = wrEnSet || wrEnClr || wrPendSet || wrPendClr || wrPrio ||
                     (wrAddrReg[31:5] == ADDR_ACTIVE[31:5]) ||
                     wrAddrReg == ADDR_LINE_COUNT || wrAddrReg == ADDR_CTRL ||
                     wrAddrReg == ADDR_EVT_STATUS || wrAddrReg == ADDR_EVT_MASK ||
                     wrAddrReg == ADDR_CORE_STATE;
  // unprivileged code may only set pending, and only when allowed
  assign wrPermit  = wrProtReg[0] ||
                     (wrPendSet && ctrlReg[CTRL_USER_PEND]);
  assign wrEff     = wrDo && wrMapped && wrPermit && wrFull;
  assign wrVec     = 256'(wrDataReg) << {wrAddrReg[4:2], 5'h00};
  assign wrLines   = wrVec[NUM_LINES-1:0];

  always_comb begin
    if (!wrMapped) begin
      wrResp = RESP_DECERR;
    end else if (!wrPermit || !wrFull) begin
      wrResp = RESP_SLVERR;
    end else begin
      wrResp = RESP_OKAY;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      awGotReg  <= 1'b0;
      wGotReg   <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      wrAddrReg <= RST_WORD;
      wrDataReg <= RST_WORD;
      wrProtReg <= 3'h0;
      wrStrbReg <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awready   <= 1'b0;
        awGotReg  <= 1'b1;
        wrAddrReg <= awaddr;
        wrProtReg <= awprot;
      end
      if (wvalid && wready) begin
        wready    <= 1'b0;
        wGotReg   <= 1'b1;
        wrDataReg <= wdata;
        wrStrbReg <= wstrb;
      end
      if (wrDo) begin
        bvalid <= 1'b1;
        bresp  <= wrResp;
      end
      if (bvalid && bready) begin
        bvalid   <= 1'b0;
        awGotReg <= 1'b0;
        wGotReg  <= 1'b0;
        awready  <= 1'b1;
        wready   <= 1'b1;
      end
    end
  end

  // ---------------- read path ----------------
  always_comb begin
    rdNext = RST_WORD;
    rrNext = RESP_OKAY;
    rdHit  = 1'b1;
    if (araddr == ADDR_LINE_COUNT) begin
      rdNext = {28'h0000000, LINE_GROUP_COUNT};
    end else if (araddr == ADDR_CTRL) begin
      rdNext = {29'h00000000, ctrlReg};
    end else if (araddr == ADDR_EVT_STATUS) begin
      rdNext = {28'h0000000, evtStatusReg};
    end else if (araddr == ADDR_EVT_MASK) begin
      rdNext = {28'h0000000, evtMaskReg};
    end else if (araddr == ADDR_CORE_STATE) begin
      rdNext = {15'h0000, sleeping, 2'h0, depthReg, actId};
    end else if (araddr[31:5] == ADDR_EN_SET[31:5] ||
                 araddr[31:5] == ADDR_EN_CLR[31:5]) begin
      rdNext = bankWord(enableReg, araddr[4:2]);
    end else if (araddr[31:5] == ADDR_PEND_SET[31:5] ||
                 araddr[31:5] == ADDR_PEND_CLR[31:5]) begin
      rdNext = bankWord(pendingReg, araddr[4:2]);
    end else if (araddr[31:5] == ADDR_ACTIVE[31:5]) begin
      rdNext = bankWord(activeReg, araddr[4:2]);
    end else if (araddr[31:8] == ADDR_PRIO[31:8] &&
                 araddr[7:2] < PRIO_WORDS && araddr[1:0] == 2'h0) begin
      for (int k = 0; k < 4; k++) begin
        rdNext[k*8 +: 8] = prioReg[{araddr[7:2], 2'(k)}];
      end
    end else begin
      rdHit = 1'b0;
    end
    if (!rdHit) begin
      rdNext = RST_WORD;
      rrNext = RESP_DECERR;
    end else if (!arprot[0]) begin
      rdNext = RST_WORD;
      rrNext = RESP_SLVERR;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= RST_WORD;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rdNext;
      rresp   <= rrNext;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ---------------- arbitration ----------------
  nvirq_arbiter u_pend_arb (
    .req      (pendingReg & enableReg),
    .prioFlat (prioFlat),
    .winValid (winValid),
    .winId    (winId),
    .winPrio  (winPrio)
  );

  // running level excludes a handler returning this cycle
  nvirq_arbiter u_act_arb (
    .req      (activeReg & ~retHot),
    .prioFlat (prioFlat),
    .winValid (actValid),
    .winId    (actId),
    .winPrio  (actPrio)
  );

  assign preempt = winValid && (!actValid || winPrio < actPrio);
  assign ackTake = irqAck && irqReq && !excReturn &&
                   depthReg != 6'(STACK_DEPTH);
  assign retTake = excReturn && depthReg != 6'h00;
  assign depthM1 = depthReg - 6'h01;
  assign retId   = stackMem[depthM1[4:0]];
  assign ackHot  = ackTake ? (240'h1 << irqId) : '0;
  assign retHot  = retTake ? (240'h1 << retId) : '0;
  assign riseVec = irqIn & ~irqPrevReg;
  // level keeps re-pending once inactive; an edge pends even when active
  assign hwSet   = (irqIn & ~(activeReg | ackHot)) |
                   (riseVec & ~ackHot);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      enableReg <= '0;
    end else if (wrEff && wrEnSet) begin
      enableReg <= enableReg | wrLines;
    end else if (wrEff && wrEnClr) begin
      enableReg <= enableReg & ~wrLines;
    end
  end

  // set sources are applied last so they win over a clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pendingReg <= '0;
      irqPrevReg <= '0;
    end else begin
      irqPrevReg <= irqIn;
      pendingReg <= (pendingReg &
                     ~((wrEff && wrPendClr) ? wrLines : '0) & ~ackHot) |
                    ((wrEff && wrPendSet) ? wrLines : '0) | hwSet;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      activeReg <= '0;
      depthReg  <= 6'h00;
    end else begin
      activeReg <= (activeReg | ackHot) & ~retHot;
      if (ackTake) begin
        stackMem[depthReg[4:0]] <= irqId;
        depthReg                <= depthReg + 6'h01;
      end else if (retTake) begin
        depthReg <= depthM1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        prioReg[i] <= 8'h00;
      end
    end else if (wrEff && wrPrio) begin
      for (int k = 0; k < 4; k++) begin
        prioReg[{wrAddrReg[7:2], 2'(k)}] <= wrDataReg[k*8 +: 8];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irqReq    <= 1'b0;
      irqId     <= 8'h00;
      irqPrio   <= 8'h00;
      tailChain <= 1'b0;
    end else begin
      irqReq    <= preempt && !ackTake;
      irqId     <= winId;
      irqPrio   <= winPrio;
      tailChain <= retTake && preempt;
    end
  end

  // ---------------- sleep and events ----------------
  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      NVIRQ_RUN: begin
        if (waitIrqInstr) begin
          stateNext = NVIRQ_SLEEP_IRQ;
        end else if (waitEventInstr && !eventLatchReg) begin
          stateNext = NVIRQ_SLEEP_EVT;
        end else if (retTake && depthReg == 6'h01 &&
                     ctrlReg[CTRL_SLEEP_EXIT]) begin
          stateNext = NVIRQ_SLEEP_IRQ;
        end
      end
      NVIRQ_SLEEP_IRQ: begin
        if (winValid) begin
          stateNext = NVIRQ_RUN;
        end
      end
      NVIRQ_SLEEP_EVT: begin
        if (winValid || sendEventInstr) begin
          stateNext = NVIRQ_RUN;
        end
      end
      default: stateNext = NVIRQ_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stateReg      <= NVIRQ_RUN;
      eventLatchReg <= 1'b0;
      sleeping      <= 1'b0;
      deepSleep     <= 1'b0;
      eventOut      <= 1'b0;
    end else begin
      stateReg  <= stateNext;
      sleeping  <= stateNext != NVIRQ_RUN;
      deepSleep <= (stateNext != NVIRQ_RUN) && ctrlReg[CTRL_DEEP_SEL];
      eventOut  <= sendEventInstr;
      if (sendEventInstr && stateReg == NVIRQ_RUN) begin
        eventLatchReg <= 1'b1;
      end else if (stateReg == NVIRQ_RUN && waitEventInstr &&
                   !waitIrqInstr) begin
        eventLatchReg <= 1'b0;
      end
    end
  end

  // ---------------- control and event registers ----------------
  always_comb begin
    evtSet                = '0;
    evtSet[EVT_BUS_FAULT] = (wrDo && wrResp == RESP_SLVERR) ||
                            (arvalid && arready && rrNext == RESP_SLVERR);
    evtSet[EVT_UNMAPPED]  = (wrDo && wrResp == RESP_DECERR) ||
                            (arvalid && arready && rrNext == RESP_DECERR);
    evtSet[EVT_SLEEP]     = stateReg == NVIRQ_RUN && stateNext != NVIRQ_RUN;
    evtSet[EVT_WAKE]      = stateReg != NVIRQ_RUN && stateNext == NVIRQ_RUN;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrlReg      <= RST_CTRL;
      evtMaskReg   <= RST_EVT;
      evtStatusReg <= RST_EVT;
      intrOut      <= 1'b0;
    end else begin
      if (wrEff && wrAddrReg == ADDR_CTRL) begin
        ctrlReg <= wrDataReg[2:0];
      end
      if (wrEff && wrAddrReg == ADDR_EVT_MASK) begin
        evtMaskReg <= wrDataReg[EVT_W-1:0];
      end
      evtStatusReg <= (evtStatusReg &
                       ~((wrEff && wrAddrReg == ADDR_EVT_STATUS) ?
                         wrDataReg[EVT_W-1:0] : RST_EVT)) | evtSet;
      intrOut <= |(evtStatusReg & evtMaskReg);
    end
  end

  // ---------------- checks ----------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      retHotQ <= '0;
    end else begin
      retHotQ <= retHot;
    end
  end

  a_line_count_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    (arvalid && arready && araddr == ADDR_LINE_COUNT && arprot[0])
    |=> rvalid && rdata == 32'h00000007 && rresp == RESP_OKAY)
    else $error("line count read wrong");

  a_active_from_ack: assert property (
    @(posedge sys_clk) disable iff (rst)
    ($past(activeReg) == '0 && !$past(ackTake)) |-> activeReg == '0)
    else $error("active bit set without acknowledge");

  a_user_fault: assert property (
    @(posedge sys_clk) disable iff (rst)
    (wrDo && wrMapped && !wrProtReg[0] &&
     !(wrPendSet && ctrlReg[CTRL_USER_PEND]))
    |=> bvalid && bresp == RESP_SLVERR)
    else $error("unprivileged write not faulted");

  a_user_pend_ok: assert property (
    @(posedge sys_clk) disable iff (rst)
    (wrDo && !wrProtReg[0] && wrPendSet && ctrlReg[CTRL_USER_PEND] && wrFull)
    |=> bresp == RESP_OKAY && ((pendingReg & $past(wrLines)) ==
                               $past(wrLines)))
    else $error("permitted user pend not applied");

  a_enable_clear: assert property (
    @(posedge sys_clk) disable iff (rst)
    (wrEff && wrEnClr) |=> (enableReg & $past(wrLines)) == '0)
    else $error("enable clear word failed");

  a_level_repend: assert property (
    @(posedge sys_clk) disable iff (rst)
    retTake ##1 ((|(retHotQ & irqIn)) && !ackTake && !wrEff)
    |=> |($past(retHotQ) & pendingReg))
    else $error("held level not pending after return");

  a_pulse_in_handler: assert property (
    @(posedge sys_clk) disable iff (rst)
    ((|(riseVec & activeReg)) && !retTake && !wrEff)
    |=> |($past(riseVec & activeReg) & pendingReg & activeReg))
    else $error("pulse during handler lost");

  a_pulse_not_counted: assert property (
    @(posedge sys_clk) disable iff (rst)
    ((|(riseVec & pendingReg)) && !ackTake && !wrEff)
    |=> |($past(riseVec & pendingReg) & pendingReg))
    else $error("pending dropped on extra pulse");

  a_sleep_on_exit: assert property (
    @(posedge sys_clk) disable iff (rst)
    (stateReg == NVIRQ_RUN && !waitIrqInstr && !waitEventInstr && retTake &&
     depthReg == 6'h01 && ctrlReg[CTRL_SLEEP_EXIT]) |=> sleeping)
    else $error("no sleep after last handler");

  a_tail_chain: assert property (
    @(posedge sys_clk) disable iff (rst)
    1'b1 |=> tailChain == $past(retTake && preempt))
    else $error("tail chain not flagged");
endmodule : nvirq_ctrl

// ### verif/nvirq_core_model.sv
`timescale 1ns/1ps
module nvirq_core_model #(
  parameter int ACK_DLY = 2
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic irqReq,
  input  wire logic ackOn,
  input  wire logic retReq,
  output logic      irqAck,
  output logic      excReturn
);
  int cnt;
  // core takes the winner after a think time, returns on request
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      irqAck <= 1'b0;
      excReturn <= 1'b0;
    end else begin
      irqAck <= 1'b0;
      excReturn <= retReq;
      if (ackOn && irqReq && !irqAck && cnt >= ACK_DLY) begin
        irqAck <= 1'b1;
        cnt <= 0;
      end else if (ackOn && irqReq && !irqAck) begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : nvirq_core_model

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import nvirq_pkg::*;
  logic sys_clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 1;
  logic arvalid = 0, rready = 1, ackOn = 0, retReq = 0;
  logic wIrq = 0, wEvt = 0, sEvt = 0, deepSleep, eventOut;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, v;
  logic [31:0] seed = 32'h00000043;
  logic [2:0] awprot = 0, arprot = 0;
  logic [1:0] bresp, rresp;
  logic [7:0] irqId, irqPrio;
  logic awready, wready, bvalid, arready, rvalid, irqReq, tailChain;
  logic sleeping, intrOut, irqAck, excReturn;
  logic [NUM_LINES-1:0] irqIn = '0;
  int error_cnt = 0, compares = 0, n, ackCnt [NUM_LINES];

  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (irqAck === 1'b1 && irqReq === 1'b1) ackCnt[irqId]++;

  nvirq_ctrl u_nvirq_ctrl (.sys_clk, .rst, .awaddr, .awprot, .awvalid,
    .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .irqIn, .irqAck, .excReturn, .waitIrqInstr(wIrq),
    .waitEventInstr(wEvt), .sendEventInstr(sEvt), .irqReq, .irqId,
    .irqPrio, .tailChain, .sleeping, .deepSleep, .eventOut, .intrOut);
  nvirq_core_model #(.ACK_DLY(2)) u_nvirq_core_model (.sys_clk, .rst,
    .irqReq, .ackOn, .retReq, .irqAck, .excReturn);

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task end_of_test;
    if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk
  task tmo(input int k);
    if (k >= 40) begin
      error_cnt++;
      end_of_test();
    end
  endtask : tmo
  task cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : cyc
  task wr(input logic [31:0] a, d, input logic [2:0] p, input logic [1:0] e);
    awaddr <= a;
    wdata <= d;
    awprot <= p;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 40);
    tmo(n);
    chk("bresp", 32'(bresp), 32'(e));
  endtask : wr
  task rd(input logic [31:0] a, input logic [2:0] p, input logic [31:0] ed,
          input logic [1:0] e);
    araddr <= a;
    arprot <= p;
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 40);
    tmo(n);
    chk("rdata", rdata, ed);
    chk("rresp", 32'(rresp), 32'(e));
  endtask : rd
  task wirq(input logic [7:0] id);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!(irqReq === 1'b1 && irqId === id) && n < 40);
    tmo(n);
  endtask : wirq
  task ret;
    retReq <= 1'b1;
    cyc(1);
    retReq <= 1'b0;
    cyc(10);
  endtask : ret

  initial begin
    cyc(20);
    rst <= 1'b0;
    cyc(1);
    rd(ADDR_LINE_COUNT, 3'h1, 32'h00000007, RESP_OKAY);
    wr(ADDR_ACTIVE, 32'hFFFFFFFF, 3'h1, RESP_OKAY);
    rd(ADDR_ACTIVE, 3'h1, RST_WORD, RESP_OKAY);
    rd(32'hE000E600, 3'h1, 32'h00000000, RESP_DECERR);
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      wr(ADDR_PRIO + 32'((i == 3) ? 236 : 4 * i), v, 3'h1, RESP_OKAY);
      rd(ADDR_PRIO + 32'((i == 3) ? 236 : 4 * i), 3'h1, v, RESP_OKAY);
    end
    v = rnd();
    wr(ADDR_EN_SET, v, 3'h1, RESP_OKAY);
    wr(ADDR_EN_CLR, 32'h0000FFFF, 3'h1, RESP_OKAY);
    rd(ADDR_EN_CLR, 3'h1, v & 32'hFFFF0000, RESP_OKAY);
    wr(ADDR_EN_CLR, 32'hFFFFFFFF, 3'h1, RESP_OKAY);
    wr(ADDR_EN_SET, 32'h00000001, 3'h0, RESP_SLVERR);
    rd(ADDR_EN_SET, 3'h0, 32'h00000000, RESP_SLVERR);
    wr(ADDR_PEND_SET, 32'h00000020, 3'h0, RESP_SLVERR);
    wr(ADDR_CTRL, 32'h00000001, 3'h1, RESP_OKAY);
    wr(ADDR_PEND_SET, 32'h00000020, 3'h0, RESP_OKAY);
    rd(ADDR_PEND_CLR, 3'h1, 32'h00000020, RESP_OKAY);
    wr(ADDR_PEND_CLR, 32'h00000020, 3'h1, RESP_OKAY);
    rd(ADDR_EVT_STATUS, 3'h1, 32'h00000003, RESP_OKAY);
    wr(ADDR_EVT_MASK, 32'h00000003, 3'h1, RESP_OKAY);
    cyc(2);
    chk("intrOut", 32'(intrOut), 32'h00000001);
    wr(ADDR_EVT_STATUS, 32'h0000000F, 3'h1, RESP_OKAY);
    cyc(2);
    chk("intrOut", 32'(intrOut), 32'h00000000);
    wr(ADDR_PRIO, 32'h40302010, 3'h1, RESP_OKAY);
    wr(ADDR_EN_SET, 32'h00000006, 3'h1, RESP_OKAY);
    irqIn[2:1] <= 2'h3;
    cyc(1);
    irqIn[2:1] <= 2'h0;
    wirq(8'h01);
    chk("irqPrio", 32'(irqPrio), 32'h00000020);
    wr(ADDR_PRIO, 32'h40102010, 3'h1, RESP_OKAY);
    wirq(8'h02);
    chk("irqPrio", 32'(irqPrio), 32'h00000010);
    ackOn <= 1'b1;
    cyc(6);
    rd(ADDR_ACTIVE, 3'h1, 32'h00000004, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      irqIn[2] <= ~irqIn[2];
      cyc(1);
    end
    rd(ADDR_PEND_SET, 3'h1, 32'h00000006, RESP_OKAY);
    retReq <= 1'b1;
    cyc(1);
    retReq <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (tailChain !== 1'b1 && n < 8);
    chk("tailChain", 32'(n < 8), 32'h00000001);
    cyc(8);
    chk("acks", 32'(ackCnt[2]), 32'h00000002);
    irqIn[3] <= 1'b1;
    wr(ADDR_EN_SET, 32'h00000008, 3'h1, RESP_OKAY);
    ret();
    ret();
    ret();
    chk("acks", 32'(ackCnt[3]), 32'h00000002);
    rd(ADDR_ACTIVE, 3'h1, 32'h00000008, RESP_OKAY);
    irqIn[3] <= 1'b0;
    wr(ADDR_CTRL, 32'h00000007, 3'h1, RESP_OKAY);
    ret();
    chk("sleeping", 32'(sleeping), 32'h00000001);
    chk("deepSleep", 32'(deepSleep), 32'h00000001);
    wr(ADDR_PEND_SET, 32'h00000002, 3'h1, RESP_OKAY);
    cyc(2);
    chk("sleeping", 32'(sleeping), 32'h00000000);
    chk("deepSleep", 32'(deepSleep), 32'h00000000);
    sEvt <= 1'b1;
    cyc(1);
    sEvt <= 1'b0;
    cyc(1);
    chk("eventOut", 32'(eventOut), 32'h00000001);
    for (int i = 0; i < 2; i++) begin
      wEvt <= 1'b1;
      cyc(1);
      wEvt <= 1'b0;
      cyc(1);
      chk("sleeping", 32'(sleeping), 32'(i));
    end
    sEvt <= 1'b1;
    cyc(1);
    sEvt <= 1'b0;
    wIrq <= 1'b1;
    cyc(1);
    chk("sleeping", 32'(sleeping), 32'h00000000);
    wIrq <= 1'b0;
    cyc(1);
    chk("sleeping", 32'(sleeping), 32'h00000001);
    end_of_test();
  end
endmodule : testbench
